// *** include/ssienc_pkg.sv ***
// constants for the serial absolute encoder frame decoder
package ssienc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OFFSET = 8'h04;
  localparam logic [7:0] OFF_PRESET = 8'h08;
  localparam logic [7:0] OFF_POINTS = 8'h0C;
  localparam logic [7:0] OFF_DIST = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_POS = 8'h18;
  localparam logic [7:0] OFF_RAW = 8'h1C;
  // control field positions
  localparam int CTL_HDR_LSB = 0;
  localparam int CTL_DBITS_LSB = 4;
  localparam int CTL_STN_LSB = 10;
  localparam int CTL_ERRPOS_LSB = 12;
  localparam int CTL_PAR_EN = 16;
  localparam int CTL_PAR_ODD = 17;
  localparam int CTL_GRAY = 18;
  localparam int CTL_INVERT = 19;
  localparam int CTL_INFINITE = 20;
  localparam int CTL_ASSIST = 21;
  // status field positions
  localparam int STS_FAULT = 0;
  localparam int STS_PARERR = 1;
  localparam int STS_ENCERR = 2;
  localparam int STS_RESOK = 3;
  localparam int STS_PEND = 4;
  localparam int STS_BITS_LSB = 8;
  localparam int STS_EXTRA = 11;
  localparam int STS_CNT_LSB = 16;
  // limits and reset values
  localparam logic [2:0] HDR_MAX = 3'h4;
  localparam logic [2:0] HDR_RST = 3'h0;
  localparam logic [4:0] DBITS_MIN_STD = 5'h0C;
  localparam logic [4:0] DBITS_MIN_ALT = 5'h10;
  localparam logic [4:0] DBITS_MAX = 5'h19;
  localparam logic [1:0] STN_RST = 2'h0;
  localparam logic [1:0] ERRPOS_RST = 2'h1;
  localparam logic [31:0] POINTS_MIN = 32'h0000_0001;
  localparam logic [31:0] POINTS_MAX = 32'h000F_4240;
  localparam logic [19:0] POINTS_RST = 20'h00001;
  localparam logic [31:0] DIST_RST = 32'h0000_0001;
  localparam logic [63:0] RES_MAX_RATIO = 64'h0000_0000_0000_03E8;
  localparam logic [24:0] OFFSET_RST = 25'h0000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FRAME_MAX = 33;
endpackage : ssienc_pkg

// *** verilog/ssienc_decoder.sv ***
// serial absolute encoder frame decoder with axi4-lite registers
`timescale 1ns/1ps
module ssienc_decoder
  import ssienc_pkg::*;
#(
  parameter bit WIDE_VARIANT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_data,
  output logic [24:0] position,
  output logic encoder_fault
);

  localparam logic [4:0] DBITS_MIN = WIDE_VARIANT ? DBITS_MIN_ALT
                                                  : DBITS_MIN_STD;

  function automatic logic [32:0] lowmask(input logic [5:0] n);
    lowmask = (33'h1 << n) - 33'h1;
  endfunction : lowmask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // link domain: shift while the frame is active
  logic [32:0] link_shift_r;

  always_ff @(posedge link_clk) begin
    if (link_frame) begin
      link_shift_r <= {link_shift_r[31:0], link_data};
    end
  end

  // frame end crossing
  logic frm_s1_r;
  logic frm_s2_r;
  logic frm_s3_r;
  logic end_evt;
  logic proc_r;
  logic [32:0] fr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_s1_r <= 1'b0;
      frm_s2_r <= 1'b0;
      frm_s3_r <= 1'b0;
    end else begin
      frm_s1_r <= link_frame;
      frm_s2_r <= frm_s1_r;
      frm_s3_r <= frm_s2_r;
    end
  end

  assign end_evt = frm_s3_r & ~frm_s2_r;

  // the link clock is quiet once the frame drops, so the word is stable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr_r <= '0;
      proc_r <= 1'b0;
    end else begin
      proc_r <= end_evt;
      if (end_evt) begin
        fr_r <= link_shift_r;
      end
    end
  end

  // configuration
  logic [2:0] hdr_r;
  logic [4:0] dbits_r;
  logic [1:0] stn_r;
  logic [1:0] errpos_r;
  logic par_en_r;
  logic par_odd_r;
  logic gray_r;
  logic invert_r;
  logic infinite_r;
  logic assist_r;
  logic [24:0] offset_r;
  logic [24:0] preset_r;
  logic pend_r;
  logic [19:0] points_r;
  logic [31:0] dist_r;
  logic res_ok;

  // decode
  logic [5:0] par_n;
  logic [5:0] dat_sh;
  logic [24:0] mask;
  logic [24:0] raw;
  logic [24:0] bin;
  logic [24:0] oriented;
  logic [24:0] pos_new;
  logic [24:0] off_calc;
  logic [2:0] sts_f;
  logic err_hit;
  logic par_bad;
  logic bad;
  logic extra_bit;

  always_comb begin
    par_n = {5'h00, par_en_r};
    dat_sh = par_n + {4'h0, stn_r};
    mask = 25'(lowmask({1'b0, dbits_r}));
    raw = 25'(fr_r >> dat_sh) & mask;
    // the msb is the same in gray and binary
    bin[24] = raw[24];
    for (int i = 23; i >= 0; i--) begin
      bin[i] = gray_r ? (bin[i+1] ^ raw[i]) : raw[i];
    end
    oriented = (invert_r && !infinite_r) ? ((mask - bin) & mask)
                                         : bin;
    pos_new = (oriented + offset_r) & mask;
    off_calc = (preset_r - oriented) & mask;
    sts_f = 3'(fr_r >> par_n) & 3'(lowmask({4'h0, stn_r}));
    err_hit = (stn_r != 2'h0) && sts_f[stn_r - errpos_r];
    extra_bit = par_en_r & par_odd_r & fr_r[0];
    par_bad = par_en_r && !par_odd_r
              && (^(fr_r & lowmask(dat_sh + {1'b0, dbits_r})));
    bad = par_bad | err_hit;
  end

  // resolution window 0.5 .. 1000 units per point
  assign res_ok = ({dist_r, 1'b0} >= {13'h0000, points_r})
                  && ({32'h0, dist_r} <= 64'(points_r) * RES_MAX_RATIO)
                  && (points_r != 20'h00000);

  // axi write channel
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_wr;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_m;
  logic [31:0] pts_m;
  logic ctrl_ok;
  logic wr_ok;

  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;

  assign ctrl_rd = {10'h000, assist_r, infinite_r, invert_r, gray_r,
                    par_odd_r, par_en_r, 2'h0, errpos_r, stn_r, 1'b0,
                    dbits_r, 1'b0, hdr_r};

  always_comb begin
    ctrl_m = merge(ctrl_rd, w_data_r, w_strb_r);
    pts_m = merge({12'h000, points_r}, w_data_r, w_strb_r);
    ctrl_ok = (ctrl_m[CTL_HDR_LSB +: 3] <= HDR_MAX)
              && (ctrl_m[CTL_DBITS_LSB +: 5] >= DBITS_MIN)
              && (ctrl_m[CTL_DBITS_LSB +: 5] <= DBITS_MAX)
              && ((ctrl_m[CTL_STN_LSB +: 2] == 2'h0)
                  || ((ctrl_m[CTL_ERRPOS_LSB +: 2] != 2'h0)
                      && (ctrl_m[CTL_ERRPOS_LSB +: 2]
                          <= ctrl_m[CTL_STN_LSB +: 2])));
    unique case (aw_addr_r)
      OFF_CTRL: wr_ok = ctrl_ok;
      OFF_POINTS: wr_ok = (pts_m >= POINTS_MIN) && (pts_m <= POINTS_MAX);
      OFF_OFFSET, OFF_PRESET, OFF_DIST, OFF_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_r <= HDR_RST;
      dbits_r <= DBITS_MIN;
      stn_r <= STN_RST;
      errpos_r <= ERRPOS_RST;
      par_en_r <= 1'b0;
      par_odd_r <= 1'b0;
      gray_r <= 1'b0;
      invert_r <= 1'b0;
      infinite_r <= 1'b0;
      assist_r <= 1'b0;
      points_r <= POINTS_RST;
      dist_r <= DIST_RST;
      preset_r <= OFFSET_RST;
    end else if (do_wr && wr_ok) begin
      unique case (aw_addr_r)
        OFF_CTRL: begin
          hdr_r <= ctrl_m[CTL_HDR_LSB +: 3];
          dbits_r <= ctrl_m[CTL_DBITS_LSB +: 5];
          stn_r <= ctrl_m[CTL_STN_LSB +: 2];
          errpos_r <= ctrl_m[CTL_ERRPOS_LSB +: 2];
          par_en_r <= ctrl_m[CTL_PAR_EN];
          par_odd_r <= ctrl_m[CTL_PAR_ODD];
          gray_r <= ctrl_m[CTL_GRAY];
          invert_r <= ctrl_m[CTL_INVERT] & ~ctrl_m[CTL_INFINITE];
          infinite_r <= ctrl_m[CTL_INFINITE];
          assist_r <= ctrl_m[CTL_ASSIST];
        end
        OFF_POINTS: points_r <= pts_m[19:0];
        OFF_DIST: dist_r <= merge(dist_r, w_data_r, w_strb_r);
        OFF_PRESET: preset_r <= 25'(merge({7'h00, preset_r}, w_data_r,
                                          w_strb_r));
        default: ;
      endcase
    end
  end

  // position, offset and fault state
  logic fault_r;
  logic parerr_r;
  logic encerr_r;
  logic [2:0] last_sts_r;
  logic last_extra_r;
  logic [15:0] frame_cnt_r;
  logic [24:0] pos_r;
  logic good_evt;
  logic bad_evt;
  logic sts_wr;

  assign good_evt = proc_r & res_ok & ~bad;
  assign bad_evt = proc_r & res_ok & bad;
  assign sts_wr = do_wr & (aw_addr_r == OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= OFFSET_RST;
      offset_r <= OFFSET_RST;
      pend_r <= 1'b0;
      frame_cnt_r <= 16'h0000;
      last_sts_r <= 3'h0;
      last_extra_r <= 1'b0;
    end else begin
      if (do_wr && wr_ok && aw_addr_r == OFF_OFFSET) begin
        offset_r <= 25'(merge({7'h00, offset_r}, w_data_r, w_strb_r));
      end
      if (do_wr && wr_ok && aw_addr_r == OFF_PRESET && assist_r) begin
        pend_r <= 1'b1;
      end
      if (proc_r) begin
        frame_cnt_r <= frame_cnt_r + 16'h0001;
        last_sts_r <= sts_f;
        last_extra_r <= extra_bit;
      end
      if (good_evt) begin
        if (pend_r) begin
          offset_r <= off_calc;
          pos_r <= preset_r & mask;
          pend_r <= 1'b0;
        end else begin
          pos_r <= pos_new;
        end
      end
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_r <= 1'b0;
      parerr_r <= 1'b0;
      encerr_r <= 1'b0;
    end else begin
      fault_r <= (fault_r & ~(sts_wr & w_data_r[STS_FAULT]))
                 | bad_evt;
      parerr_r <= (parerr_r & ~(sts_wr & w_data_r[STS_PARERR]))
                  | (bad_evt & par_bad);
      encerr_r <= (encerr_r & ~(sts_wr & w_data_r[STS_ENCERR]))
                  | (bad_evt & err_hit);
    end
  end

  assign position = pos_r;
  assign encoder_fault = fault_r;

  // axi read channel
  logic [31:0] rd_mux;

  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'h0})
      OFF_CTRL: rd_mux = ctrl_rd;
      OFF_OFFSET: rd_mux = {7'h00, offset_r};
      OFF_PRESET: rd_mux = {7'h00, preset_r};
      OFF_POINTS: rd_mux = {12'h000, points_r};
      OFF_DIST: rd_mux = dist_r;
      OFF_STATUS: rd_mux = {frame_cnt_r, 4'h0, last_extra_r, last_sts_r,
                            3'h0, pend_r, res_ok, encerr_r, parerr_r,
                            fault_r};
      OFF_POS: rd_mux = {7'h00, pos_r};
      OFF_RAW: rd_mux = {7'h00, raw};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[7:5] == 3'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  frame_end_a: assert property (frm_s3_r && !frm_s2_r |=> proc_r)
    else $error("frame end not processed");
  hdr_range_a: assert property (hdr_r <= HDR_MAX)
    else $error("header count out of range");
  dbits_range_a: assert property (dbits_r >= DBITS_MIN
    && dbits_r <= DBITS_MAX)
    else $error("data width out of range");
  inv_forced_a: assert property (infinite_r |-> !invert_r)
    else $error("inversion on infinite axis");
  fault_set_a: assert property (bad_evt |=> fault_r && $stable(pos_r))
    else $error("bad frame not flagged or position moved");
  pos_update_a: assert property (good_evt && !pend_r |=>
    pos_r == $past(pos_new))
    else $error("position not updated from frame");
  assisted_pos_a: assert property (good_evt && pend_r |=>
    pos_r == ($past(preset_r) & mask) && !pend_r)
    else $error("assisted offset not applied");
  pos_wrap_a: assert property (good_evt |=>
    (pos_r & ~$past(mask)) == 25'h0000000)
    else $error("position beyond modulo");
  pts_refuse_a: assert property (do_wr && aw_addr_r == OFF_POINTS
    && (pts_m < POINTS_MIN || pts_m > POINTS_MAX) |=>
    s_axi_bresp == RESP_SLVERR && $stable(points_r))
    else $error("point count limit not enforced");

endmodule : ssienc_decoder

// *** bench/ssienc_encoder_model.sv ***
// behavioural absolute encoder driving the serial link
`timescale 1ns/1ps
module ssienc_encoder_model (
  output logic link_clk,
  output logic link_frame,
  output logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_data = 1'b1;
  end
  // clock runs only inside a frame; hi_ns above 3 models a slow encoder
  task send(input logic [32:0] w, input int n, input int hi_ns);
    #1.3 link_frame = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      link_data = w[i];
      #3 link_clk = 1'b1;
      #(hi_ns) link_clk = 1'b0;
    end
    #2 link_frame = 1'b0;
    // released line must not keep showing the last bit
    link_data = ~link_data;
  endtask : send
endmodule : ssienc_encoder_model

// *** bench/ssienc_decoder_test.sv ***
// self-checking bench for the serial encoder frame decoder
`timescale 1ns/1ps
module ssienc_decoder_test;
  import ssienc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic link_clk;
  logic link_frame;
  logic link_data;
  logic [24:0] position;
  logic encoder_fault;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int hdr_n, dat_n, st_n, par_n;
  logic [31:0] d;
  logic [31:0] bad [5];

  always #2.5 aclk = ~aclk;

  ssienc_decoder #(.WIDE_VARIANT(1'b0)) u_ssienc_decoder (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .link_clk(link_clk),
    .link_frame(link_frame),
    .link_data(link_data),
    .position(position),
    .encoder_fault(encoder_fault)
  );

  ssienc_encoder_model u_ssienc_encoder_model (
    .link_clk(link_clk),
    .link_frame(link_frame),
    .link_data(link_data)
  );

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task axi_wr(input logic [7:0] a, input logic [31:0] v,
              input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = (s_axi_bvalid === 1'b1);
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [1:0] er,
              output logic [31:0] v);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = (s_axi_rvalid === 1'b1);
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : axi_rd

  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a, RESP_OKAY, d);
    chk(nm, e, d);
  endtask : rc

  function automatic logic [31:0] ctl(input int h, dd, s, e, f);
    return 32'(h) | 32'(dd) << CTL_DBITS_LSB | 32'(s) << CTL_STN_LSB
      | 32'(e) << CTL_ERRPOS_LSB | 32'(f) << CTL_PAR_EN;
  endfunction : ctl

  task cfg(input int h, dd, s, e, f);
    axi_wr(OFF_CTRL, ctl(h, dd, s, e, f), RESP_OKAY);
    hdr_n = h;
    dat_n = dd;
    st_n = s;
    par_n = f & 1;
  endtask : cfg

  // header bits are sent as ones so that a decoder using them shows up
  task frm(input logic [24:0] v, input logic [2:0] st, input bit flip,
           input int hi);
    logic [32:0] w;
    int n;
    w = (33'(v) << st_n) | 33'(st);
    if (par_n != 0) w = {w[31:0], ^w ^ flip};
    n = hdr_n + dat_n + st_n + par_n;
    w = w | (((33'h1 << hdr_n) - 33'h1) << (n - hdr_n));
    u_ssienc_encoder_model.send(w, n, hi);
    repeat (12) @(posedge aclk);
  endtask : frm

  task pf(input logic [24:0] e, input logic f);
    chk("position", 32'(e), 32'(position));
    chk("fault", 32'(f), 32'(encoder_fault));
  endtask : pf

  task res(input logic [31:0] p, input logic [31:0] ds, input logic ok);
    axi_wr(OFF_POINTS, p, RESP_OKAY);
    axi_wr(OFF_DIST, ds, RESP_OKAY);
    axi_rd(OFF_STATUS, RESP_OKAY, d);
    chk("res ok", 32'(ok), (d >> STS_RESOK) & 32'h1);
  endtask : res

  initial begin
    bad = '{ctl(5, 12, 0, 1, 0), ctl(0, 11, 0, 1, 0), ctl(0, 26, 0, 1, 0),
            ctl(0, 12, 2, 3, 0), ctl(0, 12, 1, 0, 0)};
    hdr_n = 0;
    dat_n = 12;
    st_n = 0;
    par_n = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFF_CTRL, 32'h0000_10C0, "ctrl");
    rc(OFF_POINTS, 32'h0000_0001, "points");
    rc(OFF_DIST, 32'h0000_0001, "dist");
    rc(OFF_OFFSET, 32'h0000_0000, "offset");
    rc(OFF_STATUS, 32'h0000_0008, "status");
    pf(25'h0, 1'b0);
    axi_rd(8'h20, RESP_SLVERR, d);
    chk("unmapped", 32'h0000_0000, d);
    axi_wr(OFF_POS, 32'h0000_0005, RESP_SLVERR);
    foreach (bad[i]) axi_wr(OFF_CTRL, bad[i], RESP_SLVERR);
    rc(OFF_CTRL, 32'h0000_10C0, "ctrl kept");
    frm(25'hA5C, 3'h0, 1'b0, 3);
    pf(25'hA5C, 1'b0);
    rc(OFF_RAW, 32'h0000_0A5C, "raw");
    rc(OFF_POS, 32'h0000_0A5C, "pos reg");
    cfg(4, 25, 3, 2, 1);
    frm(25'h1234567, 3'h5, 1'b0, 3);
    pf(25'h1234567, 1'b0);
    frm(25'h0000001, 3'h2, 1'b0, 3);
    pf(25'h1234567, 1'b1);
    axi_rd(OFF_STATUS, RESP_OKAY, d);
    chk("error flag", 32'h0000_0005, d & 32'h7);
    axi_wr(OFF_STATUS, 32'h0000_0007, RESP_OKAY);
    frm(25'h0ABCDEF, 3'h0, 1'b1, 3);
    pf(25'h1234567, 1'b1);
    axi_rd(OFF_STATUS, RESP_OKAY, d);
    chk("parity flag", 32'h0000_0003, d & 32'h7);
    axi_wr(OFF_STATUS, 32'h0000_0007, RESP_OKAY);
    pf(25'h1234567, 1'b0);
    cfg(0, 12, 0, 1, 3);
    frm(25'h3C3, 3'h0, 1'b1, 3);
    pf(25'h3C3, 1'b0);
    axi_rd(OFF_STATUS, RESP_OKAY, d);
    chk("odd bit", 32'h1, (d >> STS_EXTRA) & 32'h1);
    cfg(0, 12, 0, 1, 4);
    frm(25'h5A3 ^ (25'h5A3 >> 1), 3'h0, 1'b0, 3);
    pf(25'h5A3, 1'b0);
    cfg(0, 12, 0, 1, 8);
    frm(25'h00F, 3'h0, 1'b0, 3);
    pf(25'hFF0, 1'b0);
    frm(25'h010, 3'h0, 1'b0, 3);
    pf(25'hFEF, 1'b0);
    cfg(0, 12, 0, 1, 24);
    rc(OFF_CTRL, ctl(0, 12, 0, 1, 16), "no invert");
    frm(25'h00F, 3'h0, 1'b0, 3);
    pf(25'h00F, 1'b0);
    cfg(0, 12, 0, 1, 0);
    axi_wr(OFF_OFFSET, 32'h0000_0010, RESP_OKAY);
    frm(25'hFFF, 3'h0, 1'b0, 3);
    pf(25'h00F, 1'b0);
    cfg(0, 12, 0, 1, 32);
    axi_wr(OFF_PRESET, 32'h0000_0123, RESP_OKAY);
    axi_rd(OFF_STATUS, RESP_OKAY, d);
    chk("pending", 32'h1, (d >> STS_PEND) & 32'h1);
    frm(25'h456, 3'h0, 1'b0, 3);
    pf(25'h123, 1'b0);
    frm(25'h457, 3'h0, 1'b0, 3);
    pf(25'h124, 1'b0);
    cfg(0, 12, 0, 1, 0);
    axi_wr(OFF_POINTS, 32'h0000_0000, RESP_SLVERR);
    axi_wr(OFF_POINTS, 32'h000F_4241, RESP_SLVERR);
    res(32'h000F_4240, 32'h0000_0001, 1'b0);
    frm(25'h777, 3'h0, 1'b0, 3);
    pf(25'h124, 1'b0);
    res(32'h0000_0002, 32'h0000_07D0, 1'b1);
    res(32'h0000_0002, 32'h0000_07D1, 1'b0);
    res(32'h0000_0002, 32'h0000_0001, 1'b1);
    res(32'h0000_0003, 32'h0000_0001, 1'b0);
    test_done;
  end
endmodule : ssienc_decoder_test
